// >>> dv/acc_host.sv
`timescale 1ns/1ns
`default_nettype none
module acc_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] result_bus,
  input  wire logic [7:0] result_bus_oe,
  output logic            convert_start_n,
  output logic            chip_sel_n,
  output logic            read_strobe_n
);
  logic [7:0] bus_seen;
  // Undriven bits read back inverted so a stale value cannot pass
  assign bus_seen = (result_bus & result_bus_oe) | (~result_bus & ~result_bus_oe);
  initial begin
    convert_start_n = 1'b0;
    chip_sel_n      = 1'b1;
    read_strobe_n   = 1'b1;
  end
  task automatic set_start(input logic v, input int hold);
    @(negedge sys_clk);
    convert_start_n = v;
    repeat (hold) @(negedge sys_clk);
  endtask
  // Callers read only after busy falls, so data is never taken mid-conversion
  task automatic read_byte(output logic [7:0] d, output logic ok);
    int n;
    ok = 1'b0;
    @(negedge sys_clk);
    chip_sel_n    = 1'b0;
    read_strobe_n = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge sys_clk);
      ok = (result_bus_oe === 8'hFF);
    end
    d = bus_seen;
    read_strobe_n = 1'b1;
    chip_sel_n    = 1'b1;
    // Strobes pass a 2-flop sync, so allow the release to land
    repeat (6) @(negedge sys_clk);
    ok = ok && (result_bus_oe === 8'h00);
  endtask
  // Chip select alone must not open the data buffers
  task automatic select_only(input int hold, output logic quiet);
    int k;
    quiet = 1'b1;
    @(negedge sys_clk);
    chip_sel_n = 1'b0;
    for (k = 0; k < hold; k++) begin
      @(negedge sys_clk);
      quiet = quiet && (result_bus_oe === 8'h00);
    end
    chip_sel_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_acc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_acc_ctrl;
  import acc_pkg::*;
  logic       sys_clk, rst, busy, powered, high_speed_mode, tracking;
  logic       cs_n, rd_n, start_n, ok;
  logic [9:0] sample_code;
  logic [7:0] result_bus, result_bus_oe, d;
  int         error_cnt = 0;
  int         checks = 0;
  int         n;
  acc_ctrl acc_ctrl_i (.sys_clk(sys_clk), .rst(rst), .convert_start_n(start_n),
    .chip_sel_n(cs_n), .read_strobe_n(rd_n), .sample_code(sample_code), .busy(busy),
    .powered(powered), .high_speed_mode(high_speed_mode), .tracking(tracking),
    .result_bus(result_bus), .result_bus_oe(result_bus_oe));
  acc_host acc_host_i (.sys_clk(sys_clk), .result_bus(result_bus),
    .result_bus_oe(result_bus_oe), .convert_start_n(start_n), .chip_sel_n(cs_n),
    .read_strobe_n(rd_n));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wait_busy(input logic lvl, output int cnt);
    cnt = 0;
    while (busy !== lvl && cnt < 1000) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask
  task automatic rd(input logic [7:0] exp);
    acc_host_i.read_byte(d, ok);
    check("oe", 1, ok);
    check("byte", exp, d);
  endtask
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic check_reset();
    check("powered", 0, powered);
    check("tracking", 1, tracking);
    check("oe", 0, result_bus_oe);
  endtask
  // Short start pulse, low well before busy falls: auto power-down
  task automatic conv_auto();
    acc_host_i.set_start(1'b1, 2);
    acc_host_i.set_start(1'b0, 0);
    wait_busy(1'b1, n);
    check("start wait", 1, n >= 185 && n <= 195);
    check("tracking", 0, tracking);
    check("powered", 1, powered);
    wait_busy(1'b0, n);
    check("busy len", CONV_CYC, n);
    check("tracking", 1, tracking);
    repeat (2) @(negedge sys_clk);
    check("mode", 0, high_speed_mode);
    check("powered", 0, powered);
    rd(sample_code[9:2]);
    rd({sample_code[1:0], 6'h00});
    rd(sample_code[9:2]);
    acc_host_i.select_only(8, ok);
    check("oe cs only", 1, ok);
  endtask
  // Long start pulse, high again at busy fall: high speed
  task automatic conv_fast();
    sample_code = 10'h0FF;
    acc_host_i.set_start(1'b1, 250);
    acc_host_i.set_start(1'b0, 0);
    wait_busy(1'b1, n);
    check("fall start", 1, n <= 6);
    acc_host_i.set_start(1'b1, 0);
    wait_busy(1'b0, n);
    check("mode", 1, high_speed_mode);
    check("powered", 1, powered);
    rd(8'h3F);
    sample_code = 10'h301;
    repeat (20) @(negedge sys_clk);
    acc_host_i.set_start(1'b0, 0);
    wait_busy(1'b1, n);
    check("fast start", 1, n <= 6);
    wait_busy(1'b0, n);
    check("mode", 0, high_speed_mode);
    rd(8'hC0);
  endtask
  initial begin
    rst = 1'b1;
    sample_code = 10'h2B5;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    check_reset();
    conv_auto();
    conv_fast();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire

// >>> pkg/acc_pkg.sv
`default_nettype none
package acc_pkg;
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned PWRUP_NS     = 1500;
  localparam int unsigned CONV_NS      = 2300;
  localparam int unsigned PWRUP_CYC    = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC     = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RES_BITS     = 10;
  localparam int unsigned CODE_STEPS   = 1024;
  localparam int unsigned CNT_W        = 9;
  localparam logic [9:0]  RESULT_RST   = 10'h000;
  localparam logic [7:0]  BUS_RST      = 8'h00;
  localparam int unsigned LOW_BITS_POS = 6;
  typedef enum logic [1:0] {ACC_OFF, ACC_IDLE, ACC_CONV} acc_state_t;
endpackage
`default_nettype wire

// >>> verilog/acc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module acc_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       convert_start_n,
  input  wire logic       chip_sel_n,
  input  wire logic       read_strobe_n,
  input  wire logic [9:0] sample_code,
  output logic            busy,
  output logic            powered,
  output logic            high_speed_mode,
  output logic            tracking,
  output logic [7:0]      result_bus,
  output logic [7:0]      result_bus_oe
);
  import acc_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic             cs_s1, cs_s2, rd_s1, rd_s2, st_s1, st_s2;
  logic             st_d, rd_d, cs_d, gated_d;
  logic             pulse;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] conv_cnt;
  logic [CNT_W-1:0] busy_run;
  logic [CNT_W-1:0] pulse_run;
  logic [9:0]       result;
  logic             low_sel;
  acc_state_t       state;
  logic             st_rise, gated, gated_fall, rd_rise, rd_active, conv_done;

  // Terminal count of a span, so every user agrees on the off-by-one
  function automatic logic [CNT_W-1:0] cnt_last(input int unsigned cycles);
    cnt_last = CNT_W'(cycles - 1);
  endfunction

  // Pins come from outside the clock domain
  always_ff @(posedge sys_clk) begin
    st_s1 <= convert_start_n;
    st_s2 <= st_s1;
    cs_s1 <= chip_sel_n;
    cs_s2 <= cs_s1;
    rd_s1 <= read_strobe_n;
    rd_s2 <= rd_s1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_d    <= 1'b0;
      rd_d    <= 1'b1;
      cs_d    <= 1'b1;
      gated_d <= 1'b0;
    end else begin
      st_d    <= st_s2;
      rd_d    <= rd_s2;
      cs_d    <= cs_s2;
      gated_d <= gated;
    end
  end

  assign st_rise    = st_s2 && !st_d;
  assign gated      = st_s2 || pulse;
  assign gated_fall = gated_d && !gated;
  // Select as it stood a cycle back, so a joint release of both strobes still counts
  assign rd_rise    = rd_s2 && !rd_d && !cs_d;
  assign rd_active  = !cs_s2 && !rd_s2;
  assign conv_done  = (state == ACC_CONV) && (conv_cnt == cnt_last(CONV_CYC));

  ////////////////////////////////////////////////////////////////
  // Power-up pulse; retriggers on every rising edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse     <= 1'b0;
      pulse_cnt <= '0;
    end else if (st_rise) begin
      pulse     <= 1'b1;
      pulse_cnt <= '0;
    end else if (pulse) begin
      pulse_cnt <= pulse_cnt + 1'b1;
      if (pulse_cnt == cnt_last(PWRUP_CYC)) begin
        pulse <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Conversion sequencer; reset models the supply coming up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ACC_OFF;
      conv_cnt <= '0;
    end else begin
      unique case (state)
        ACC_OFF: begin
          if (st_rise) begin
            state <= ACC_IDLE;
          end
        end
        ACC_IDLE: begin
          conv_cnt <= '0;
          if (gated_fall) begin
            state <= ACC_CONV;
          end
        end
        ACC_CONV: begin
          conv_cnt <= conv_cnt + 1'b1;
          if (conv_done) begin
            state <= st_s2 ? ACC_IDLE : ACC_OFF;
          end
        end
      endcase
    end
  end

  // Busy and track move on the same edge as hold begins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy     <= 1'b0;
      tracking <= 1'b1;
    end else if (state == ACC_IDLE && gated_fall) begin
      busy     <= 1'b1;
      tracking <= 1'b0;
    end else if (conv_done) begin
      busy     <= 1'b0;
      tracking <= 1'b1;
    end
  end

  // Start level at end of conversion decides whether power stays on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      powered         <= 1'b0;
      high_speed_mode <= 1'b0;
    end else if (conv_done) begin
      high_speed_mode <= st_s2;
      powered         <= st_s2;
    end else if (state == ACC_OFF && st_rise) begin
      powered <= 1'b1;
    end
  end

  // Analog front end supplies a straight binary code
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result <= RESULT_RST;
    end else if (conv_done) begin
      result <= sample_code;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read port stays live in every state, including power-down
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_sel <= 1'b0;
    end else if (state == ACC_IDLE && gated_fall) begin
      low_sel <= 1'b0;
    end else if (rd_rise) begin
      low_sel <= !low_sel;
    end
  end

  // Registered drive: bus follows the strobes a few clocks late
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_bus    <= BUS_RST;
      result_bus_oe <= 8'h00;
    end else begin
      result_bus_oe <= {8{rd_active}};
      if (low_sel) begin
        result_bus <= {result[1:0], 6'h00};
      end else begin
        result_bus <= result[9:2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Run lengths counted apart from the sequencer, so length checks stand alone
  always_ff @(posedge sys_clk) begin
    if (rst || !busy) begin
      busy_run <= '0;
    end else begin
      busy_run <= busy_run + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || st_rise || !pulse) begin
      pulse_run <= '0;
    end else begin
      pulse_run <= pulse_run + 1'b1;
    end
  end

  a_busy_len: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy) |-> busy [*8] ##0 (conv_cnt != '0 || busy))
    else $error("busy too short");
  a_busy_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy) |-> $past(gated_fall))
    else $error("busy rose without gated start fall");
  a_pulse_len: assert property (@(posedge sys_clk) disable iff (rst)
    st_rise |=> pulse [*8])
    else $error("power-up pulse too short");
  a_pulse_end: assert property (@(posedge sys_clk) disable iff (rst)
    pulse && pulse_cnt == cnt_last(PWRUP_CYC) && !st_rise |=> !pulse)
    else $error("pulse overran");
  a_mode_pick: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) |-> high_speed_mode == $past(st_s2))
    else $error("mode not taken from start level");
  a_latch_res: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) |-> result == $past(sample_code) && tracking)
    else $error("result not latched at end");
  a_bus_drive: assert property (@(posedge sys_clk) disable iff (rst)
    result_bus_oe != 8'h00 |-> $past(rd_active))
    else $error("bus driven outside read");
  a_seq_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy) |-> !low_sel)
    else $error("read sequence not reset");
  a_low_bits: assert property (@(posedge sys_clk) disable iff (rst)
    $past(low_sel) |-> result_bus[5:0] == 6'h00)
    else $error("low read bits not zero");
  a_no_conv_off: assert property (@(posedge sys_clk) disable iff (rst)
    state == ACC_OFF |=> !$rose(busy))
    else $error("converted while powered down");

  // Conversion timing and mode
  a_busy_total: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) |-> busy_run == CNT_W'(CONV_CYC))
    else $error("busy length wrong");
  a_pulse_total: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(pulse) |-> pulse_run == CNT_W'(PWRUP_CYC))
    else $error("power-up pulse length wrong");
  a_conv_wait: assert property (@(posedge sys_clk) disable iff (rst)
    pulse || st_s2 |=> !$rose(busy))
    else $error("conversion began while gated start high");
  a_conv_ignore: assert property (@(posedge sys_clk) disable iff (rst)
    state == ACC_CONV && !conv_done |=> state == ACC_CONV && busy)
    else $error("conversion cut short");
  a_off_stay: assert property (@(posedge sys_clk) disable iff (rst)
    state == ACC_OFF && !st_rise |=> state == ACC_OFF)
    else $error("left power-down without start edge");
  a_wake_up: assert property (@(posedge sys_clk) disable iff (rst)
    state == ACC_OFF && st_rise |=> powered && state == ACC_IDLE)
    else $error("start edge did not power up");
  a_power_mode: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) |-> powered == high_speed_mode)
    else $error("power state does not match mode");
  a_busy_power: assert property (@(posedge sys_clk) disable iff (rst)
    busy |-> powered)
    else $error("busy while unpowered");
  a_track_hold: assert property (@(posedge sys_clk) disable iff (rst)
    busy |-> !tracking)
    else $error("tracking during conversion");
  a_result_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(conv_done) |-> $stable(result))
    else $error("result changed outside end of conversion");

  // Readout
  a_oe_on: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rd_active) |-> result_bus_oe == 8'hFF)
    else $error("bus not driven during read");
  a_high_byte: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rd_active && !low_sel) |-> result_bus == $past(result[9:2]))
    else $error("high byte wrong");
  a_low_byte: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rd_active && low_sel) |-> result_bus[7:6] == $past(result[1:0]))
    else $error("low bits wrong");
  a_sel_toggle: assert property (@(posedge sys_clk) disable iff (rst)
    rd_rise && !(state == ACC_IDLE && gated_fall) |=> low_sel != $past(low_sel))
    else $error("byte selector did not advance");

  c_high_speed: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) && st_s2);
  c_power_down: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(busy) && !st_s2);
  c_two_reads: cover property (@(posedge sys_clk) disable iff (rst)
    rd_rise ##[1:100] rd_rise);
  c_ext_late: cover property (@(posedge sys_clk) disable iff (rst)
    gated_fall && !pulse && gated_d && state == ACC_IDLE);
  c_read_asleep: cover property (@(posedge sys_clk) disable iff (rst)
    rd_rise && !powered);
endmodule
`default_nettype wire
